/* File: eeprom_cmd_pkg.sv */
package eeprom_cmd_pkg;

  // --------------------------------------------------------------
  // opcodes
  // --------------------------------------------------------------
  // latch, status and array codes
  localparam logic [7:0] OP_SET_LATCH    = 8'h06;
  localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;

  // --------------------------------------------------------------
  // status byte layout and reset values
  // --------------------------------------------------------------
  localparam int         STAT_LOCK   = 7;
  localparam int         STAT_BP_HI  = 3;
  localparam int         STAT_BP_LO  = 2;
  localparam int         STAT_WEL    = 1;
  localparam int         STAT_WIP    = 0;
  localparam logic       LOCK_RESET  = 1'b0;
  localparam logic [1:0] BP_RESET    = 2'h0;

  // --------------------------------------------------------------
  // frame sizes and addressing
  // --------------------------------------------------------------
  localparam int BYTE_BITS       = 8;
  localparam int STAT_WR_BITS    = 16;
  localparam int ARRAY_WR_MIN    = 40;
  localparam int ADDR_BYTES_END  = 32;
  localparam int ADDR_W          = 24;
  localparam int SIG_ADDR_W      = 17;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int T_WRITE_MS      = 5;
  localparam int CLK_PERIOD_NS   = 20;
  localparam int WRITE_CYCLES    = T_WRITE_MS * 1000000 / CLK_PERIOD_NS;

  // one of the six defined opcodes
  function automatic logic opcode_known(input logic [7:0] op);
    return (op == OP_SET_LATCH) || (op == OP_CLEAR_LATCH) ||
           (op == OP_STATUS_READ) || (op == OP_STATUS_WRITE) ||
           (op == OP_ARRAY_READ) || (op == OP_ARRAY_WRITE);
  endfunction

  // address falls in the read-only region chosen by the protect bits
  // quarter, half, whole array
  function automatic logic region_hit(input logic [1:0] bp, input logic a16,
                                      input logic a15);
    return (bp == 2'h3) || ((bp == 2'h2) && a16) || ((bp == 2'h1) && a16 && a15);
  endfunction

endpackage

/* File: pin_sync3.sv */
`timescale 1ns/10ps
module pin_sync3 #(
  parameter logic INIT = 1'b1
) (
  input  wire logic clk_in,     // system clock
  input  wire logic resetn_in,  // sync reset, active low
  input  wire logic pin_in,     // asynchronous pin
  output logic      level_out   // filtered level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // three stages; level moves only when stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s1_q    <= INIT;
      s2_q    <= INIT;
      s3_q    <= INIT;
      level_q <= INIT;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) level_q <= s3_q;
    end
  end

  assign level_out = level_q;

endmodule // pin_sync3

/* File: serial_eeprom_cmd_protect.sv */
// Behaviour
// - writes execute only when the clock count is a whole number of bytes
// - modifying instructions need the write enable latch set beforehand
// - final bit is eighth of opcode or data byte; reads exempt
// - protect bits choose none, upper quarter, upper half or whole array
// - the write protect pin guards the protect bits
// - opcodes: set latch 06, clear latch 04, status read 05
// - opcodes: status write 01, array read 03, array write 02
// - unknown opcode: device ignores the rest of the frame
// - only address bits 16 down to 0 are used
// - only set latch sets the latch, completed at deselect
// - clear latch resets the latch, completed at deselect
// - latch clears at reset, clear latch, and end of write cycles
// - status read works at any time and repeats the byte
// - busy flag is one during a write cycle, else zero
// - with the latch clear all write instructions are rejected
// - protect bits change only by status write outside locked mode
// - array write into the protected region changes nothing
// - lock bit set and protect pin low locks the status register
// - msb first, sampled on rising edges, output on falling edges
// - deselect after a valid status write starts a timed cycle
// - array read is refused while a write cycle runs
`timescale 1ns/10ps
module serial_eeprom_cmd_protect
  import eeprom_cmd_pkg::*;
#(
  parameter int TW_CYCLES = WRITE_CYCLES,
  parameter int CNT_W     = 12
) (
  input  wire logic                  clk_in,                // system clock
  input  wire logic                  resetn_in,             // sync reset, low
  input  wire logic                  spi_clk_in,            // serial clock
  input  wire logic                  cs_n_in,               // chip select, low
  input  wire logic                  mosi_in,               // serial data in
  input  wire logic                  wp_n_in,               // write protect, low
  output logic                       miso_out,              // serial data out
  output logic                       miso_oe_out,           // data out enable
  output logic [7:0]                 status_out,            // status byte
  output logic                       write_in_progress_out, // busy flag
  output logic                       hardware_locked_mode_out, // locked
  output logic                       mem_write_go_out,      // start array write
  output logic [SIG_ADDR_W-1:0]      mem_write_addr_out,    // write address
  output logic                       array_read_go_out      // read accepted
);

  localparam int TW_W = $clog2(TW_CYCLES + 1);

  // ----------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------
  logic              rst_link_n_q;
  logic              tog_raw;
  logic [7:0]        op_raw;
  logic [CNT_W-1:0]  cnt_raw;
  logic [7:0]        data_raw;
  logic [ADDR_W-1:0] addr_raw;
  logic [7:0]        status_byte;

  // registered reset so the link flops see a clean release
  always_ff @(posedge clk_in) begin
    rst_link_n_q <= resetn_in;
  end

  spi_link_shift #(
    .CNT_W (CNT_W)
  ) u_link (
    .spi_clk_in    (spi_clk_in),
    .cs_n_in       (cs_n_in),
    .rst_n_in      (rst_link_n_q),
    .mosi_in       (mosi_in),
    .status_in     (status_byte),
    .miso_out      (miso_out),
    .miso_oe_out   (miso_oe_out),
    .frame_tog_out (tog_raw),
    .opcode_out    (op_raw),
    .bit_count_out (cnt_raw),
    .data_byte_out (data_raw),
    .addr_out      (addr_raw),
    .read_go_out   (array_read_go_out)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cs_level;
  logic wp_level;

  pin_sync3 #(
    .INIT (1'b1)
  ) u_cs_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .pin_in    (cs_n_in),
    .level_out (cs_level)
  );

  pin_sync3 #(
    .INIT (1'b1)
  ) u_wp_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .pin_in    (wp_n_in),
    .level_out (wp_level)
  );

  // ----------------------------------------------------------------
  // frame capture at deselect
  // ----------------------------------------------------------------
  logic              cs_prev_q;
  logic              tog_s1_q;
  logic              tog_s2_q;
  logic              tog_seen_q;
  logic              exec_q;
  logic              fresh_q;
  logic [7:0]        op_c_q;
  logic [CNT_W-1:0]  cnt_c_q;
  logic [7:0]        data_c_q;
  logic [ADDR_W-1:0] addr_c_q;
  logic              cs_rise;

  // reset value high: a deselect needs a falling edge after reset first
  assign cs_rise = cs_level && !cs_prev_q;

  // toggle crossing tells a real frame from a select pulse with no clocks
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cs_prev_q  <= 1'b1;
      tog_s1_q   <= 1'b0;
      tog_s2_q   <= 1'b0;
      tog_seen_q <= 1'b0;
      exec_q     <= 1'b0;
      fresh_q    <= 1'b0;
    end else begin
      cs_prev_q <= cs_level;
      tog_s1_q  <= tog_raw;
      tog_s2_q  <= tog_s1_q;
      exec_q    <= cs_rise;
      if (cs_rise) begin
        fresh_q    <= (tog_s2_q != tog_seen_q);
        tog_seen_q <= tog_s2_q;
      end
    end
  end

  // link clock is stopped while deselected, so these words are static here
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      op_c_q   <= 8'h00;
      cnt_c_q  <= '0;
      data_c_q <= 8'h00;
      addr_c_q <= '0;
    end else if (cs_rise) begin
      op_c_q   <= op_raw;
      cnt_c_q  <= cnt_raw;
      data_c_q <= data_raw;
      addr_c_q <= addr_raw;
    end
  end

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  logic       wel_q;
  logic       busy_q;
  logic       lock_q;
  logic [1:0] bp_q;
  logic       cmd_ok;
  logic       whole_bytes;
  logic       locked;
  logic       prot_hit;
  logic       go_set;
  logic       go_clear;
  logic       go_sw;
  logic       go_mw;

  // unknown opcodes fall through every decode
  assign cmd_ok      = exec_q && fresh_q && opcode_known(op_c_q);
  assign whole_bytes = (cnt_c_q[2:0] == 3'h0);
  // lock bit with protect pin low
  assign locked      = lock_q && !wp_level;
  assign prot_hit    = region_hit(bp_q, addr_c_q[SIG_ADDR_W-1], addr_c_q[SIG_ADDR_W-2]);

  // exact count means select rose before the next edge
  assign go_set   = cmd_ok && (op_c_q == OP_SET_LATCH) && (cnt_c_q == CNT_W'(BYTE_BITS));
  assign go_clear = cmd_ok && (op_c_q == OP_CLEAR_LATCH) &&
                    (cnt_c_q == CNT_W'(BYTE_BITS));
  // eighth bit of the data byte ends a status write
  assign go_sw    = cmd_ok && (op_c_q == OP_STATUS_WRITE) &&
                    (cnt_c_q == CNT_W'(STAT_WR_BITS)) && wel_q && !locked && !busy_q;
  assign go_mw    = cmd_ok && (op_c_q == OP_ARRAY_WRITE) && whole_bytes &&
                    (cnt_c_q >= CNT_W'(ARRAY_WR_MIN)) && wel_q && !busy_q && !prot_hit;

  // ----------------------------------------------------------------
  // self-timed write cycle
  // ----------------------------------------------------------------
  logic [TW_W-1:0] tw_q;
  logic            kind_sw_q;
  logic            pend_lock_q;
  logic [1:0]      pend_bp_q;
  logic            cycle_end;
  logic            sw_end;

  assign cycle_end = busy_q && (tw_q == '0);
  assign sw_end    = cycle_end && kind_sw_q;

  // deselect at byte boundary starts the cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      busy_q <= 1'b0;
      tw_q   <= '0;
    end else if (go_sw || go_mw) begin
      busy_q <= 1'b1;
      tw_q   <= TW_W'(TW_CYCLES - 1);
    end else if (cycle_end) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      tw_q <= tw_q - TW_W'(1);
    end
  end

  // new status bits wait until the cycle completes
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      kind_sw_q   <= 1'b0;
      pend_lock_q <= LOCK_RESET;
      pend_bp_q   <= BP_RESET;
    end else if (go_sw || go_mw) begin
      kind_sw_q   <= go_sw;
      pend_lock_q <= data_c_q[STAT_LOCK];
      pend_bp_q   <= data_c_q[STAT_BP_HI:STAT_BP_LO];
    end
  end

  // protect and lock bits change only at status write end
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      lock_q <= LOCK_RESET;
      bp_q   <= BP_RESET;
    end else if (sw_end) begin
      lock_q <= pend_lock_q;
      bp_q   <= pend_bp_q;
    end
  end

  // latch set wins over a clearing event in the same cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) wel_q <= 1'b0;
    else if (go_set) wel_q <= 1'b1;
    else if (go_clear || cycle_end) wel_q <= 1'b0;
  end

  // only significant address bits leave the block
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mem_write_go_out   <= 1'b0;
      mem_write_addr_out <= '0;
    end else begin
      mem_write_go_out <= go_mw;
      if (go_mw) mem_write_addr_out <= addr_c_q[SIG_ADDR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // busy flag in bit zero
  assign status_byte              = {lock_q, 3'h0, bp_q, wel_q, busy_q};
  assign status_out               = status_byte;
  assign write_in_progress_out    = busy_q;
  assign hardware_locked_mode_out = locked;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence sw_start_s;
    go_sw;
  endsequence

  sequence busy_two_s;
    write_in_progress_out [*2];
  endsequence

  latch_set_src_a: assert property ($rose(wel_q) |-> $past(go_set))
    else $error("latch set without set instruction");
  latch_clear_a: assert property (go_clear && !go_set |=> !wel_q)
    else $error("clear instruction left latch set");
  end_clears_a: assert property (cycle_end && !go_set |=> !status_out[STAT_WEL])
    else $error("write cycle end left latch set");
  write_needs_latch_a: assert property ((go_sw || go_mw) |-> wel_q)
    else $error("write started with latch clear");
  busy_flag_a: assert property (sw_start_s |=> busy_two_s)
    else $error("busy flag not raised after status write");
  lock_reject_a: assert property (locked |-> !go_sw)
    else $error("status write taken in locked mode");
  byte_count_a: assert property (mem_write_go_out |-> $past(cnt_c_q[2:0]) == 3'h0)
    else $error("array write with partial byte");
  prot_block_a: assert property (cmd_ok && op_c_q == OP_ARRAY_WRITE && prot_hit
                                 |=> !mem_write_go_out)
    else $error("write started inside protected region");
  nv_hold_a: assert property ($changed(bp_q) || $changed(lock_q) |-> $past(sw_end))
    else $error("protect bits changed outside status write");
  unknown_op_a: assert property (exec_q && !opcode_known(op_c_q) && !busy_q
                                 |=> $stable(wel_q) && !busy_q)
    else $error("unknown opcode had an effect");

endmodule // serial_eeprom_cmd_protect

/* File: serial_eeprom_cmd_protect_tb.sv */
`timescale 1ns/10ps
module serial_eeprom_cmd_protect_tb;
  import eeprom_cmd_pkg::*;
  logic                  clk_in, resetn_in, wp_n_in, spi_clk, cs_n, mosi, miso, miso_oe;
  logic [7:0]            status_out, rx;
  logic                  write_in_progress_flag, locked, go, rd_go, rd_seen, oe_seen;
  logic [SIG_ADDR_W-1:0] waddr;
  logic [23:0]           exp_q[$], addr_q[$], seen_v, a;
  int                    n_mismatch, samples_checked, seed;

  serial_eeprom_cmd_protect #(.TW_CYCLES(200)) dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .spi_clk_in(spi_clk), .cs_n_in(cs_n),
    .mosi_in(mosi), .wp_n_in(wp_n_in), .miso_out(miso), .miso_oe_out(miso_oe),
    .status_out(status_out), .write_in_progress_out(write_in_progress_flag),
    .hardware_locked_mode_out(locked), .mem_write_go_out(go),
    .mem_write_addr_out(waddr), .array_read_go_out(rd_go));
  spi_master_model m (.spi_clk_out(spi_clk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso), .rx_out(rx));

  // --------------------------------------------------------------
  // clock and link-side observers
  // --------------------------------------------------------------
  initial clk_in = 1'b0;
  always #10 clk_in = ~clk_in;
  always @(posedge spi_clk) begin
    rd_seen |= (rd_go === 1'b1);
    oe_seen |= (miso_oe === 1'b1);
  end

  // --------------------------------------------------------------
  // checking
  // --------------------------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  event got;
  // oldest note against the result just handed over
  always @(got) chk(seen_v, exp_q.pop_front());
  // each write start must match a noted address
  always @(posedge clk_in) begin
    if (go === 1'b1) begin
      if (addr_q.size() == 0) chk(24'h1, 24'h0);
      else chk({7'h00, waddr}, addr_q.pop_front());
    end
  end
  task automatic note(input logic [23:0] v, input logic [23:0] e);
    exp_q.push_back(e);
    seen_v = v;
    ->got;
    #1;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic settle();
    repeat (12) @(posedge clk_in);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 1000 && write_in_progress_flag !== 1'b0; k++) @(posedge clk_in);
    if (k == 1000) begin
      n_mismatch++;
      results();
    end
    settle();
  endtask
  task automatic st(input logic [7:0] e);
    settle();
    note({16'h0, status_out}, {16'h0, e});
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    seed = 91061;
    resetn_in = 1'b0;
    wp_n_in = 1'b1;
    rd_seen = 1'b0;
    oe_seen = 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    settle();
    st(8'h00);
    m.frame({8'h01, 8'h8c}, 16);
    st(8'h00);
    m.frame(8'h06, 8);
    st(8'h02);
    m.frame(8'h04, 8);
    st(8'h00);
    m.frame(8'h06, 9);
    st(8'h00);
    m.frame(8'hff, 16);
    note(oe_seen, 0);
    m.frame(8'h06, 8);
    // two status bytes back to back; the second one is checked
    m.frame({8'h05, 16'h0}, 24);
    note(rx, 8'h02);
    m.frame({8'h01, 8'h84}, 16);
    m.frame({8'h05, 8'h00}, 16);
    note(rx, 8'h03);
    // the nine-bit frame above decodes as a read; forget it
    rd_seen = 1'b0;
    m.frame({8'h03, 24'h0}, 32);
    note(rd_seen, 0);
    wait_idle();
    st(8'h84);
    // quarter protection edge, junk in the ignored upper address bits
    for (int k = 0; k < 3; k++) begin
      a = 24'($random(seed));
      a[16:0] = (k == 1) ? 17'h18000 : 17'h17fff;
      m.frame(8'h06, 8);
      if (k == 0) addr_q.push_back({7'h00, a[16:0]});
      // pass 2 carries one stray bit after the data byte
      m.frame({8'h02, a, 8'($random(seed)), 1'b1} >> (k != 2), 40 + (k == 2));
      st((k == 0) ? 8'h87 : 8'h86);
      wait_idle();
    end
    @(posedge clk_in);
    wp_n_in <= 1'b0;
    settle();
    note(locked, 1);
    m.frame({8'h01, 8'h00}, 16);
    st(8'h86);
    @(posedge clk_in);
    wp_n_in <= 1'b1;
    settle();
    m.frame({8'h01, 8'h00}, 16);
    wait_idle();
    st(8'h00);
    m.frame({8'h03, 24'h0}, 32);
    note(rd_seen, 1);
    chk(24'(addr_q.size()), 24'h0);
    results();
  end
endmodule // serial_eeprom_cmd_protect_tb

/* File: spi_link_shift.sv */
`timescale 1ns/10ps
module spi_link_shift
  import eeprom_cmd_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input  wire logic              spi_clk_in,    // serial clock
  input  wire logic              cs_n_in,       // chip select, active low
  input  wire logic              rst_n_in,      // async reset from core
  input  wire logic              mosi_in,       // serial data in
  input  wire logic [7:0]        status_in,     // status byte, core domain
  output logic                   miso_out,      // serial data out
  output logic                   miso_oe_out,   // data out drive enable
  output logic                   frame_tog_out, // flips once per frame
  output logic [7:0]             opcode_out,    // first byte of frame
  output logic [CNT_W-1:0]       bit_count_out, // rising edges in frame
  output logic [7:0]             data_byte_out, // last whole byte
  output logic [ADDR_W-1:0]      addr_out,      // address bytes
  output logic                   read_go_out    // array read accepted
);

  logic              seen_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [7:0]        shift_q;
  logic [7:0]        shift_d;
  logic [7:0]        op_q;
  logic [7:0]        cur_op;
  logic [7:0]        data_q;
  logic [7:0]        tx_q;
  logic [7:0]        stat_s1_q;
  logic [7:0]        stat_s2_q;
  logic [ADDR_W-1:0] addr_q;
  logic              tog_q;
  logic              miso_q;
  logic              oe_q;
  logic              byte_done;
  logic              op_load;
  logic              addr_load;
  logic              tx_load;
  logic              past_op;

  // frame start marker; cleared by deselect, counters keep their values
  always_ff @(posedge spi_clk_in or posedge cs_n_in) begin
    if (cs_n_in) seen_q <= 1'b0;
    else         seen_q <= 1'b1;
  end

  // counting and decode, msb first
  assign cnt_d     = !seen_q ? CNT_W'(1) : ((&cnt_q) ? cnt_q : cnt_q + CNT_W'(1));
  assign shift_d   = {shift_q[6:0], mosi_in};
  assign byte_done = (cnt_d[2:0] == 3'h0);
  assign op_load   = (cnt_d == CNT_W'(BYTE_BITS));
  assign cur_op    = op_load ? shift_d : op_q;
  assign addr_load = byte_done && (cnt_d > CNT_W'(BYTE_BITS)) &&
                     (cnt_d <= CNT_W'(ADDR_BYTES_END));
  assign tx_load   = byte_done && (cur_op == OP_STATUS_READ);
  assign past_op   = (cnt_q >= CNT_W'(BYTE_BITS));

  // input side, sampled on rising edges
  always_ff @(posedge spi_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q   <= '0;
      shift_q <= 8'h00;
      op_q    <= 8'h00;
      addr_q  <= '0;
      data_q  <= 8'h00;
      tog_q   <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      if (op_load) op_q <= shift_d;
      if (addr_load) addr_q <= {addr_q[ADDR_W-9:0], shift_d};
      if (byte_done && !op_load) data_q <= shift_d;
      if (!seen_q) tog_q <= ~tog_q;
    end
  end

  // status byte reload at every byte boundary of a status read; flags are independent bits
  always_ff @(posedge spi_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_s1_q <= 8'h00;
      stat_s2_q <= 8'h00;
      tx_q      <= 8'h00;
    end else begin
      stat_s1_q <= status_in;
      stat_s2_q <= stat_s1_q;
      tx_q      <= tx_load ? stat_s2_q : {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(negedge spi_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      miso_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      miso_q <= tx_q[7];
      oe_q   <= past_op && (op_q == OP_STATUS_READ);
    end
  end

  assign miso_out      = miso_q;
  assign miso_oe_out   = oe_q && !cs_n_in;
  assign frame_tog_out = tog_q;
  assign opcode_out    = op_q;
  assign bit_count_out = cnt_q;
  assign data_byte_out = data_q;
  assign addr_out      = addr_q;
  assign read_go_out   = past_op && (op_q == OP_ARRAY_READ) && !stat_s2_q[STAT_WIP] && !cs_n_in;

endmodule // spi_link_shift

/* File: spi_master_model.sv */
`timescale 1ns/10ps
module spi_master_model (
  output logic       spi_clk_out, // link clock, low between frames
  output logic       cs_n_out,    // select, active low
  output logic       mosi_out,    // data to device
  input  wire logic  miso_in,     // data from device
  output logic [7:0] rx_out       // last eight bits read back
);
  // --------------------------------------------------------------
  // idle state
  // --------------------------------------------------------------
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out    = 1'b1;
    mosi_out    = 1'b0;
    rx_out      = 8'h00;
  end

  // --------------------------------------------------------------
  // one frame of n bits, 64 ns link period
  // --------------------------------------------------------------
  // msb first, rising sample
  task automatic frame(input logic [63:0] bits, input int n);
    cs_n_out = 1'b0;
    #37;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_out = bits[i];
      #32 spi_clk_out = 1'b1;
      rx_out = {rx_out[6:0], miso_in};
      #32 spi_clk_out = 1'b0;
    end
    #11 cs_n_out = 1'b1;
    // released line flips so stale data never looks valid
    mosi_out = ~mosi_out;
    #200;
  endtask
endmodule // spi_master_model
